// file: core/sample_fifo_pkg.sv
// Shared constants for the sample buffer control block
package sample_fifo_pkg;
    // Register indices and byte addresses (byte address is four times the index)
    localparam logic [7:0]  IDX_CONTROL    = 8'h3A;
    localparam logic [7:0]  IDX_STATUS     = 8'h3B;
    localparam logic [7:0]  IDX_MASK       = 8'h3C;
    localparam logic [7:0]  IDX_DATA       = 8'h3D;
    localparam logic [7:0]  IDX_LIMIT      = 8'h3E;
    localparam logic [7:0]  ADDR_CONTROL   = 8'(IDX_CONTROL * 4);
    localparam logic [7:0]  ADDR_STATUS    = 8'(IDX_STATUS * 4);
    localparam logic [7:0]  ADDR_MASK      = 8'(IDX_MASK * 4);
    localparam logic [7:0]  ADDR_DATA      = 8'(IDX_DATA * 4);
    localparam logic [7:0]  ADDR_LIMIT     = 8'(IDX_LIMIT * 4);
    // Control register layout
    localparam logic [23:0] CONTROL_RESET  = 24'h040200;
    localparam logic [23:0] CONTROL_WMASK  = 24'h0FFFFF;
    localparam int          MODE_LSB       = 16;
    localparam int          HEADER_BIT     = 18;
    localparam int          STATUS_BIT     = 19;
    localparam int          RSVD_BIT       = 15;
    localparam int          WR_ERR_EN_BIT  = 14;
    localparam int          RD_ERR_EN_BIT  = 13;
    localparam int          UPPER_EN_BIT   = 12;
    localparam int          OVERRUN_EN_BIT = 10;
    localparam int          WMARK_EN_BIT   = 9;
    // Status register layout
    localparam int          ST_WMARK       = 0;
    localparam int          ST_OVERRUN     = 1;
    localparam int          ST_RD_ERR      = 2;
    localparam int          ST_WR_ERR      = 3;
    localparam int          ST_UPPER       = 4;
    localparam logic [4:0]  MASK_RESET     = 5'h1F;
    localparam logic [8:0]  LIMIT_RESET    = 9'h100;
    // Buffer geometry
    localparam int          DEPTH          = 256;
    localparam logic [8:0]  FULL_COUNT     = 9'h100;
    // Operating modes
    localparam logic [1:0]  MODE_OFF       = 2'h0;
    localparam logic [1:0]  MODE_WMARK     = 2'h1;
    // Kinds of words on the readout stream
    localparam logic [1:0]  KIND_STATUS    = 2'h0;
    localparam logic [1:0]  KIND_HEADER    = 2'h1;
    localparam logic [1:0]  KIND_DATA      = 2'h2;
    typedef enum logic [1:0] {S_IDLE, S_STAT, S_HEAD, S_DATA} read_state_t;
endpackage

// file: core/sample_fifo_ctrl.sv
// Sample buffer control: APB registers, 256-entry store, readout sequencer, interrupt
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module sample_fifo_ctrl
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Conversion results from the converter core
    input  wire logic        conv_valid,
    input  wire logic [23:0] conv_data,
    input  wire logic [3:0]  conv_tag,
    // Readout stream towards the serial port
    input  wire logic        rd_cmd,
    output logic             out_valid,
    input  wire logic        out_ready,
    output logic [23:0]      out_word,
    output logic [1:0]       out_kind,
    // Interrupt
    output logic             irq
);
    import sample_fifo_pkg::*;
    logic [23:0] control;
    logic [4:0]  status;
    logic [4:0]  mask;
    logic [23:0] data_reg;
    logic [8:0]  limit;
    logic [27:0] mem [DEPTH];
    logic [7:0]  wr_ptr;
    logic [7:0]  rd_ptr;
    logic [8:0]  count;
    logic        locked;
    read_state_t state;
    read_state_t next_state;
    logic [1:0]  mode;
    logic        enabled;
    logic [8:0]  wmark_n;
    logic        push_req;
    logic        accept;
    logic        dropped;
    logic        evict;
    logic        pop;
    logic [8:0]  next_count;
    logic        wr_access;
    logic        rd_access;
    logic        mapped;
    logic        status_rd;
    logic        rd_err_ev;
    logic        wr_err_ev;
    logic [4:0]  events;
    logic [4:0]  ctrl_en;
    logic        next_valid;
    logic [23:0] next_word;
    logic [1:0]  next_kind;
    // Decoded control fields
    assign mode    = control[MODE_LSB+1:MODE_LSB];
    assign enabled = (mode != MODE_OFF);
    assign wmark_n = (control[7:0] == 8'h00) ? FULL_COUNT : {1'b0, control[7:0]};
    // APB decode: zero wait states, error on unmapped addresses
    assign wr_access = psel && penable && pwrite;
    assign rd_access = psel && penable && !pwrite;
    assign mapped    = (paddr == ADDR_CONTROL) || (paddr == ADDR_STATUS) ||
                       (paddr == ADDR_MASK) || (paddr == ADDR_DATA) || (paddr == ADDR_LIMIT);
    assign pready    = penable;
    assign pslverr   = psel && penable && !mapped;
    assign status_rd = rd_access && (paddr == ADDR_STATUS);
    // Read data loaded in the setup phase, stands through access; reserved bits read zero except control bits 8, 11 and RSVD_BIT, which read back as written
    always_ff @(posedge core_clk)
    begin
        if (reset)
            prdata <= 32'h0000_0000;
        else if (psel && !penable)
        begin
            unique case (paddr)
                ADDR_CONTROL: prdata <= {8'h00, control & CONTROL_WMASK};
                ADDR_STATUS:  prdata <= {27'h0, status};
                ADDR_MASK:    prdata <= {27'h0, mask};
                ADDR_DATA:    prdata <= {8'h00, data_reg};
                ADDR_LIMIT:   prdata <= {23'h0, limit};
                default:      prdata <= 32'h0000_0000;
            endcase
        end
    end
    // Writable registers
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            control <= CONTROL_RESET;
            mask    <= MASK_RESET;
            limit   <= LIMIT_RESET;
        end
        else if (wr_access)
        begin
            if (paddr == ADDR_CONTROL)
                control <= pwdata[23:0] & CONTROL_WMASK;
            if (paddr == ADDR_MASK)
                mask <= pwdata[4:0];
            if (paddr == ADDR_LIMIT)
                limit <= pwdata[8:0];
        end
    end
    // Plain data register always holds the latest conversion
    always_ff @(posedge core_clk)
    begin
        if (reset)
            data_reg <= 24'h000000;
        else if (conv_valid)
            data_reg <= conv_data;
    end
    // Store admission, drop and eviction decisions
    always_comb
    begin
        push_req = conv_valid && enabled;
        if (mode == MODE_WMARK)
        begin
            accept = push_req && !locked && ((count - 9'(pop)) < wmark_n);
            evict  = 1'b0;
        end
        else
        begin
            accept = push_req;
            evict  = push_req && (count == FULL_COUNT) && !pop;
        end
        dropped    = push_req && !accept;
        next_count = count + 9'(accept) - 9'(pop || evict);
    end
    // Storage array write
    always_ff @(posedge core_clk)
    begin
        if (accept)
            mem[wr_ptr] <= {conv_tag, conv_data};
    end
    // Pointers, fill level and the watermark lock; disabling flushes the store
    always_ff @(posedge core_clk)
    begin
        if (reset || !enabled)
        begin
            wr_ptr <= 8'h00;
            rd_ptr <= 8'h00;
            count  <= 9'h000;
            locked <= 1'b0;
        end
        else
        begin
            wr_ptr <= wr_ptr + 8'(accept);
            rd_ptr <= rd_ptr + 8'(pop || evict);
            count  <= next_count;
            if (mode != MODE_WMARK || next_count == 9'h000)
                locked <= 1'b0;
            else if (accept && next_count == wmark_n)
                locked <= 1'b1;
        end
    end
    // Flag events; all gated by an enabled buffer
    assign rd_err_ev = rd_cmd && (!enabled || count == 9'h000 || state != S_IDLE);
    assign wr_err_ev = wr_access && (paddr == ADDR_CONTROL) && pwdata[RSVD_BIT];
    always_comb
    begin
        events[ST_WMARK]   = enabled && (count < wmark_n) && (next_count >= wmark_n);
        events[ST_OVERRUN] = (mode == MODE_WMARK) ? dropped : evict;
        events[ST_RD_ERR]  = enabled && rd_err_ev;
        events[ST_WR_ERR]  = enabled && wr_err_ev;
        events[ST_UPPER]   = enabled && (count < limit) && (next_count >= limit);
    end
    // Sticky status; a read clears only the bits it returned, so a late event is kept
    always_ff @(posedge core_clk)
    begin
        if (reset)
            status <= 5'h00;
        else
            status <= (status & ~(status_rd ? prdata[4:0] : 5'h00)) | events;
    end
    // Interrupt: sticky bit, mask bit and its control enable must all be set
    always_comb
    begin
        ctrl_en[ST_WMARK]   = control[WMARK_EN_BIT];
        ctrl_en[ST_OVERRUN] = control[OVERRUN_EN_BIT];
        ctrl_en[ST_RD_ERR]  = control[RD_ERR_EN_BIT];
        ctrl_en[ST_WR_ERR]  = control[WR_ERR_EN_BIT];
        ctrl_en[ST_UPPER]   = control[UPPER_EN_BIT];
        irq = |(status & mask & ctrl_en);
    end
    // Readout sequencer: optional status once, then optional header and data per sample
    always_comb
    begin
        next_state = state;
        next_valid = out_valid;
        next_word  = out_word;
        next_kind  = out_kind;
        pop        = 1'b0;
        unique case (state)
            S_IDLE:
            begin
                if (rd_cmd && enabled && count != 9'h000)
                begin
                    next_valid = 1'b1;
                    if (control[STATUS_BIT])
                    begin
                        next_state = S_STAT;
                        next_word  = {19'h0, status};
                        next_kind  = KIND_STATUS;
                    end
                    else if (control[HEADER_BIT])
                    begin
                        next_state = S_HEAD;
                        next_word  = {20'h0, mem[rd_ptr][27:24]};
                        next_kind  = KIND_HEADER;
                    end
                    else
                    begin
                        next_state = S_DATA;
                        next_word  = mem[rd_ptr][23:0];
                        next_kind  = KIND_DATA;
                        pop        = 1'b1;
                    end
                end
            end
            S_HEAD:
            begin
                if (out_ready)
                begin
                    next_state = S_DATA;
                    next_word  = mem[rd_ptr][23:0];
                    next_kind  = KIND_DATA;
                    pop        = 1'b1;
                end
            end
            S_STAT, S_DATA:
            begin
                if (out_ready)
                begin
                    if (count == 9'h000 || !enabled)
                    begin
                        next_state = S_IDLE;
                        next_valid = 1'b0;
                    end
                    else if (control[HEADER_BIT])
                    begin
                        next_state = S_HEAD;
                        next_word  = {20'h0, mem[rd_ptr][27:24]};
                        next_kind  = KIND_HEADER;
                    end
                    else
                    begin
                        next_state = S_DATA;
                        next_word  = mem[rd_ptr][23:0];
                        next_kind  = KIND_DATA;
                        pop        = 1'b1;
                    end
                end
            end
        endcase
    end
    // Sequencer registers; output word and kind come from flip-flops
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            state     <= S_IDLE;
            out_valid <= 1'b0;
            out_word  <= 24'h000000;
            out_kind  <= KIND_STATUS;
        end
        else
        begin
            state     <= next_state;
            out_valid <= next_valid;
            out_word  <= next_word;
            out_kind  <= next_kind;
        end
    end
    // Checks
    a_mode_reset_off: assert property (@(posedge core_clk)
        $fell(reset) |-> (mode == MODE_OFF && control[HEADER_BIT] && !control[STATUS_BIT]))
        else $error("control did not reset to its documented value");
    a_off_no_store: assert property (@(posedge core_clk) disable iff (reset)
        (!enabled) |=> (count == 9'h000 &&
        status[ST_OVERRUN] == $past(status[ST_OVERRUN] && !(status_rd && prdata[ST_OVERRUN]))))
        else $error("disabled buffer stored data or raised overrun");
    a_wmark_bound: assert property (@(posedge core_clk) disable iff (reset)
        (mode == MODE_WMARK && $past(mode) == MODE_WMARK) |-> (count <= wmark_n))
        else $error("watermark mode exceeded its count");
    a_wmark_drop: assert property (@(posedge core_clk) disable iff (reset)
        (mode == MODE_WMARK && locked && conv_valid) |=> (wr_ptr == $past(wr_ptr)))
        else $error("locked watermark buffer accepted a result");
    a_wmark_overrun: assert property (@(posedge core_clk) disable iff (reset)
        (mode == MODE_WMARK && conv_valid && !accept) |=> status[ST_OVERRUN])
        else $error("dropped result did not set overrun");
    a_stream_evict: assert property (@(posedge core_clk) disable iff (reset)
        (mode[1] && conv_valid && count == FULL_COUNT && !pop) |=>
        (count == FULL_COUNT && rd_ptr == $past(rd_ptr) + 8'h01))
        else $error("full streaming buffer did not evict oldest");
    a_stream_overrun: assert property (@(posedge core_clk) disable iff (reset)
        (mode[1] && evict) |=> status[ST_OVERRUN])
        else $error("eviction did not set overrun");
    a_pop_frees: assert property (@(posedge core_clk) disable iff (reset)
        (enabled && pop && !accept && $stable(mode)) |=> (count == $past(count) - 9'h001))
        else $error("readout did not free a slot");
    a_header_first: assert property (@(posedge core_clk) disable iff (reset)
        (out_valid && out_kind == KIND_DATA && $changed(out_word) && control[HEADER_BIT])
        |-> ($past(out_kind) == KIND_HEADER))
        else $error("sample sent without its header");
    a_status_once: assert property (@(posedge core_clk) disable iff (reset)
        (state == S_STAT) |-> ($past(state) == S_IDLE || $past(state) == S_STAT))
        else $error("status word repeated within one read");
    a_irq_gate: assert property (@(posedge core_clk) disable iff (reset)
        (status[ST_OVERRUN] && mask[ST_OVERRUN] && control[OVERRUN_EN_BIT]) |-> irq)
        else $error("enabled overrun did not raise interrupt");
    a_rsvd_zero: assert property (@(posedge core_clk) disable iff (reset)
        (rd_access && paddr == ADDR_CONTROL) |-> (prdata[31:20] == 12'h000))
        else $error("reserved control bits read nonzero");
endmodule

// file: dv/serial_host_model.sv
// Host model: issues read commands and drains the readout stream
`timescale 1ns/1ps
module serial_host_model
(
    // Clock
    input  wire logic        core_clk,
    // Readout stream
    output logic             rd_cmd,
    input  wire logic        out_valid,
    output logic             out_ready,
    input  wire logic [23:0] out_word,
    input  wire logic [1:0]  out_kind
);
    logic [23:0] words [$];
    logic [1:0]  kinds [$];
    logic        hung;
    // Idle host: no command, not taking words
    initial
    begin
        rd_cmd    = 1'b0;
        out_ready = 1'b0;
        hung      = 1'b0;
    end
    // One command, then take words until the stream ends; stall halves the take rate
    task automatic fetch(input logic stall);
        int n;
        words.delete();
        kinds.delete();
        @(posedge core_clk);
        rd_cmd    <= 1'b1;
        out_ready <= 1'b1;
        @(posedge core_clk);
        rd_cmd <= 1'b0;
        for (n = 0; n < 2000; n++)
        begin
            @(posedge core_clk);
            if (out_valid !== 1'b1)
                break;
            if (out_ready)
            begin
                words.push_back(out_word);
                kinds.push_back(out_kind);
            end
            out_ready <= stall ? ~out_ready : 1'b1;
        end
        hung = (n == 2000);
    endtask
endmodule

// file: dv/adc_sample_fifo_control_tb.sv
// Self-checking bench for the sample buffer control block
`timescale 1ns/1ps
module adc_sample_fifo_control_tb;
    import sample_fifo_pkg::*;
    logic        core_clk, reset, psel, penable, pwrite, pready, pslverr, slv_err;
    logic        conv_valid, rd_cmd, out_valid, out_ready, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [23:0] conv_data, out_word;
    logic [3:0]  conv_tag;
    logic [1:0]  out_kind;
    int          error_cnt, n_compared;

    sample_fifo_ctrl i_sample_fifo_ctrl (.core_clk(core_clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .conv_valid(conv_valid), .conv_data(conv_data),
        .conv_tag(conv_tag), .rd_cmd(rd_cmd), .out_valid(out_valid), .out_ready(out_ready),
        .out_word(out_word), .out_kind(out_kind), .irq(irq));
    serial_host_model i_serial_host_model (.core_clk(core_clk), .rd_cmd(rd_cmd),
        .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word), .out_kind(out_kind));

    // 4 ns clock
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic summarize;
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // APB transfer; read data and error are taken at the pready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge core_clk);
            if (pready === 1'b1)
                break;
        end
        if (n == 50)
        begin
            error_cnt++;
            summarize();
        end
        rd      = prdata;
        slv_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic conv(input int cnt, input logic [23:0] base);
        for (int i = 0; i < cnt; i++)
        begin
            @(posedge core_clk);
            conv_valid <= 1'b1;
            conv_data  <= base + 24'(i);
            conv_tag   <= 4'(i);
        end
        @(posedge core_clk);
        conv_valid <= 1'b0;
    endtask

    task automatic fetch(input logic stall);
        i_serial_host_model.fetch(stall);
        if (i_serial_host_model.hung)
        begin
            error_cnt++;
            summarize();
        end
    endtask

    task automatic irq_is(input logic e);
        @(posedge core_clk);
        chk({31'h0, irq}, {31'h0, e});
    endtask

    // Reset values, reserved bits, unmapped access, disabled buffer
    task automatic t_regs;
        apb(1'b0, ADDR_CONTROL, 32'h0);
        chk(rd, 32'h0004_0200);
        apb(1'b0, ADDR_MASK, 32'h0);
        chk(rd, 32'h0000_001F);
        apb(1'b0, 8'h00, 32'h0);
        chk({31'h0, slv_err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, ADDR_CONTROL, 32'h00F4_0000);
        apb(1'b0, ADDR_CONTROL, 32'h0);
        chk(rd, 32'h0004_0000);
        conv(3, 24'h000ABC);
        apb(1'b0, ADDR_DATA, 32'h0);
        chk(rd, 32'h0000_0ABE);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h0);
    endtask

    // Watermark of three: fourth result dropped, slow drain, storing resumes
    task automatic t_wmark;
        apb(1'b1, ADDR_CONTROL, 32'h0001_0003);
        conv(4, 24'h000100);
        irq_is(1'b0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h0000_0003);
        fetch(1'b1);
        chk(i_serial_host_model.words.size(), 3);
        for (int i = 0; i < 3; i++)
        begin
            chk(32'(i_serial_host_model.words[i]), 32'h100 + i);
            chk(32'(i_serial_host_model.kinds[i]), 32'(KIND_DATA));
        end
        conv(1, 24'h000200);
        fetch(1'b0);
        chk(i_serial_host_model.words.size(), 1);
        chk(32'(i_serial_host_model.words[0]), 32'h200);
    endtask

    // Streaming: 257 results into 256 places, oldest evicted, status and headers
    task automatic t_stream;
        apb(1'b1, ADDR_CONTROL, 32'h0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        apb(1'b1, ADDR_CONTROL, 32'h000E_0000);
        conv(257, 24'h001000);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({31'h0, rd[ST_OVERRUN]}, 32'h1);
        chk({31'h0, rd[ST_WMARK]}, 32'h1);
        fetch(1'b0);
        chk(i_serial_host_model.words.size(), 513);
        chk(32'(i_serial_host_model.kinds[0]), 32'(KIND_STATUS));
        chk(32'(i_serial_host_model.kinds[1]), 32'(KIND_HEADER));
        chk(32'(i_serial_host_model.words[1]), 32'h1);
        chk(32'(i_serial_host_model.words[2]), 32'h1001);
        chk(32'(i_serial_host_model.words[512]), 32'h1100);
    endtask

    // Interrupt: raise, mask, clear on read, the overrun, write error, read error and upper enable bits
    task automatic t_irq;
        apb(1'b1, ADDR_CONTROL, 32'h0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        apb(1'b1, ADDR_CONTROL, 32'h0001_0401);
        conv(2, 24'h0);
        irq_is(1'b1);
        apb(1'b1, ADDR_MASK, 32'h1D);
        irq_is(1'b0);
        apb(1'b1, ADDR_MASK, 32'h1F);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({31'h0, rd[ST_OVERRUN]}, 32'h1);
        irq_is(1'b0);
        apb(1'b1, ADDR_CONTROL, 32'h0001_C001);
        irq_is(1'b1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({31'h0, rd[ST_WR_ERR]}, 32'h1);
        apb(1'b1, ADDR_CONTROL, 32'h0);
        apb(1'b1, ADDR_CONTROL, 32'h0001_2001);
        fetch(1'b0);
        irq_is(1'b1);
        apb(1'b1, ADDR_CONTROL, 32'h0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        apb(1'b1, ADDR_LIMIT, 32'h2);
        apb(1'b1, ADDR_CONTROL, 32'h0001_1000);
        conv(2, 24'h0);
        irq_is(1'b1);
    endtask

    // Main sequence
    initial
    begin
        error_cnt  = 0;
        n_compared = 0;
        reset      = 1'b1;
        {psel, penable, pwrite, conv_valid} = 4'h0;
        paddr      = 8'h00;
        pwdata     = 32'h0;
        conv_data  = 24'h0;
        conv_tag   = 4'h0;
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        t_regs();
        t_wmark();
        t_stream();
        t_irq();
        summarize();
    end

    // Hang guard
    initial
    begin
        #400000;
        error_cnt++;
        summarize();
    end
endmodule
